// ===== gtm_pkg.sv
/*
  general timer module constants, field layouts and carrier types.
  assumes nothing beyond a SystemVerilog-2012 compiler.
*/
package gtm_pkg;
  // global configuration field
  localparam logic [2:0] CFG_WIDE = 3'h0;
  localparam logic [2:0] CFG_RTC = 3'h1;
  localparam logic [2:0] CFG_SPLIT = 3'h4;
  // timer mode field
  localparam logic [1:0] TM_ONESHOT = 2'h1;
  localparam logic [1:0] TM_PERIODIC = 2'h2;
  localparam logic [1:0] TM_CAPTURE = 2'h3;
  // event select
  localparam logic [1:0] EV_RISE = 2'h0;
  localparam logic [1:0] EV_FALL = 2'h1;
  localparam logic [1:0] EV_BOTH = 2'h3;
  // reset and reload values
  localparam logic [15:0] LOAD_RST = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] PRE_ZERO = 8'h00;
  localparam logic [7:0] PRE_ONE = 8'h01;
  localparam logic [31:0] RTC_START = 32'h0000_0001;
  localparam logic [31:0] C32_ZERO = 32'h0000_0000;
  localparam logic [31:0] C32_ONE = 32'h0000_0001;
  localparam logic [31:0] C32_RST = 32'hFFFF_FFFF;
  // rtc input divider: 32.768 kHz down to 1 Hz
  localparam int RTC_IN_HZ = 32768;
  localparam int RTC_OUT_HZ = 1;
  localparam logic [14:0] DIV_ZERO = 15'h0000;
  localparam logic [14:0] DIV_ONE = 15'h0001;
  localparam logic [14:0] DIV_LAST = 15'(RTC_IN_HZ / RTC_OUT_HZ - 1);
  localparam int HALF = 16;

  typedef struct packed {
    logic       alternate_mode_select;
    logic       capture_mode_bit;
    logic [1:0] timer_mode_field;
  } gtm_mode_t;

  typedef struct packed {
    logic [1:0] event_sel;
    logic       pwm_output_level_bit;
    logic       stall;
  } gtm_ctl_t;

  typedef struct packed {
    logic cap_event;
    logic cap_match;
    logic timeout;
  } gtm_flags_t;

  localparam gtm_flags_t FLAGS_NONE = 3'h0;
endpackage

// ===== gtm_core.sv
/*
  general timer module: two 16-bit timers or one 32-bit timer/rtc.
  assumes configuration inputs are held steady while a timer is enabled
  and capture pins are synchronous-free levels from outside.
*/
// Operation
// - prescaler bypassed in edge count, edge time and pwm modes.
// - capture bit clear makes a down edge counter on rise, fall or both.
// - each selected edge decrements from load value until the decremented count would equal match.
// - count match sets capture-match raw flag, masked flag when unmasked.
// - after match reload counter, clear enable, ignore edges until re-enabled.
// - capture bit set makes free-running down counter; rise or fall only.
// - each selected edge copies counter to readback, sets capture-event flag.
// - edge time keeps counting while enabled; reloads after reaching zero.
// - captured value holds until the next selected edge.
// - pwm mode is alternate select 1, capture bit 0, mode field 2.
// - pwm counts down to zero then reloads next cycle, until disabled.
// - pwm mode sets no status flags.
// - pwm output asserts at load value, deasserts at match value.
// - output level bit inverts the pwm output.
// - config 0 wide timer, 1 rtc, 4 two 16-bit timers.
// - mode field 1 one-shot, 2 periodic, in wide and split configs.
// - one-shot stops after timeout; periodic continues.
// - writing a clear bit clears raw and masked flag.
// - rtc match sets rtc raw flag; counting continues until disabled.
// - 16-bit one-shot/periodic reloads load and prescale after zero.
// - rtc stall override keeps rtc counting during debug halt.
// - wide load value is timer b load over timer a load.
`timescale 1ns/100ps
module gtm_core (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     arst_n,
  input  wire logic                     clk_en,
  // configuration
  input  wire logic [2:0]               global_config_field,
  input  wire gtm_pkg::gtm_mode_t [1:0] per_timer_mode_reg,
  input  wire gtm_pkg::gtm_ctl_t [1:0]  timer_control_reg,
  input  wire logic                     rtc_stall_override_bit,
  input  wire logic                     debug_halt,
  // enable control pulses
  input  wire logic [1:0]               en_set,
  input  wire logic [1:0]               en_clr,
  // load, match, prescale
  input  wire logic [1:0][15:0]         interval_load_value,
  input  wire logic [1:0][15:0]         match_value,
  input  wire logic [1:0][7:0]          prescale_value,
  // status control
  input  wire gtm_pkg::gtm_flags_t [1:0] interrupt_mask_reg,
  input  wire gtm_pkg::gtm_flags_t [1:0] status_clear_reg,
  input  wire logic                     rtc_match_mask,
  input  wire logic                     rtc_match_clear,
  // pins
  input  wire logic [1:0]               capture_compare_pin,
  output logic [1:0]                    pwm_out,
  // state
  output logic [1:0]                    timer_en,
  output logic [1:0][15:0]              timer_value_readback,
  output gtm_pkg::gtm_flags_t [1:0]     raw_status_reg,
  output gtm_pkg::gtm_flags_t [1:0]     masked_status_reg,
  output logic                          rtc_match_raw_flag,
  output logic                          rtc_match_masked_flag
);
  import gtm_pkg::*;

  logic [1:0]       sy1_reg, sy2_reg, old_reg, rise, fall;
  logic [1:0]       en_reg, en_next, lvl_reg, lvl_next, pwm_reg;
  logic [1:0][15:0] cnt_reg, cnt_next, val_reg, val_next;
  logic [1:0][7:0]  pre_reg, pre_next;
  gtm_flags_t [1:0] raw_reg, raw_next, msk_reg, set_f;
  logic [1:0]       cm_hit, ce_hit, to_hit, pwr_v, ev_any;
  logic [31:0]      c32_reg, c32_next;
  logic [14:0]      div_reg, div_next;
  logic             rtc_reg, rtc_next, rmsk_reg;

  // configuration decode
  wire split = global_config_field == CFG_SPLIT;
  wire wide = global_config_field == CFG_WIDE;
  wire rtc_md = global_config_field == CFG_RTC;
  wire [1:0] tm32 = per_timer_mode_reg[0].timer_mode_field;
  wire ovr = rtc_stall_override_bit & rtc_md;
  wire halt_a = debug_halt & timer_control_reg[0].stall & ~ovr;

  // wide one-shot / periodic and rtc
  wire [31:0] load32 = {interval_load_value[1], interval_load_value[0]};
  wire [31:0] match32 = {match_value[1], match_value[0]};
  wire wide_md = tm32 == TM_ONESHOT || tm32 == TM_PERIODIC;
  wire run32 = en_reg[0] & ~halt_a & wide & wide_md;
  wire to32 = run32 & (c32_reg == C32_ZERO);
  wire clr32 = to32 & (tm32 == TM_ONESHOT);
  wire rtc_run = rtc_md & en_reg[0] & ~halt_a;
  wire rtc_ev = rtc_run & rise[0];
  wire rtc_tick = rtc_ev & (div_reg == DIV_LAST);
  wire rtc_hit = rtc_tick & (c32_reg == match32);

  always_comb begin
    c32_next = c32_reg;
    if (rtc_md & ~en_reg[0]) begin
      c32_next = RTC_START;
    end else if (wide & ~en_reg[0]) begin
      c32_next = load32;
    end else if (rtc_hit) begin
      c32_next = C32_ZERO;
    end else if (rtc_tick) begin
      c32_next = c32_reg + C32_ONE;
    end else if (to32) begin
      c32_next = load32;
    end else if (run32) begin
      c32_next = c32_reg - C32_ONE;
    end
  end

  assign div_next = ~rtc_run ? DIV_ZERO
                  : ~rtc_ev ? div_reg
                  : rtc_tick ? DIV_ZERO : div_reg + DIV_ONE;
  assign rtc_next = (rtc_reg & ~rtc_match_clear) | rtc_hit;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      c32_reg <= C32_RST;
      div_reg <= DIV_ZERO;
      rtc_reg <= 1'b0;
      rmsk_reg <= 1'b0;
    end else if (clk_en) begin
      c32_reg <= c32_next;
      div_reg <= div_next;
      rtc_reg <= rtc_next;
      rmsk_reg <= rtc_next & rtc_match_mask;
    end
  end

  // per-timer 16-bit channels
  for (genvar i = 0; i < 2; i++) begin : g_ch
    gtm_mode_t m;
    gtm_ctl_t  c;
    assign m = per_timer_mode_reg[i];
    assign c = timer_control_reg[i];
    assign rise[i] = sy2_reg[i] & ~old_reg[i];
    assign fall[i] = ~sy2_reg[i] & old_reg[i];
    wire [15:0] ilr = interval_load_value[i];
    wire [15:0] mat = match_value[i];
    wire [15:0] cnt = cnt_reg[i];
    wire [1:0] md = m.timer_mode_field;
    wire run = en_reg[i] & split & ~(debug_halt & c.stall);
    wire capm = md == TM_CAPTURE;
    wire pwm_md = m.alternate_mode_select & ~m.capture_mode_bit & md == TM_PERIODIC;
    wire ecnt = run & capm & ~m.capture_mode_bit;
    wire etim = run & capm & m.capture_mode_bit;
    wire prd = run & ~m.alternate_mode_select & (md == TM_ONESHOT || md == TM_PERIODIC);
    assign pwr_v[i] = run & pwm_md;
    wire rsel = c.event_sel == EV_RISE;
    wire fsel = c.event_sel == EV_FALL;
    wire bsel = c.event_sel == EV_BOTH;
    assign ev_any[i] = (rsel & rise[i]) | (fsel & fall[i]) | (bsel & (rise[i] | fall[i]));
    wire ev_one = fsel ? fall[i] : rise[i];
    wire zero = cnt == CNT_ZERO;
    wire pre_zero = pre_reg[i] == PRE_ZERO;
    wire tick = prd & pre_zero;
    wire free_run = etim | pwr_v[i] | tick;
    wire [15:0] dec = cnt - CNT_ONE;
    assign cm_hit[i] = ecnt & ev_any[i] & (dec == mat);
    assign ce_hit[i] = etim & ev_one;
    assign to_hit[i] = tick & zero;
    wire os_stop = to_hit[i] & (md == TM_ONESHOT);
    wire hw_clr = cm_hit[i] | os_stop | (i == 0 && clr32);

    always_comb begin
      cnt_next[i] = cnt;
      if (~en_reg[i]) begin
        cnt_next[i] = ilr;
      end else if (cm_hit[i]) begin
        cnt_next[i] = ilr;
      end else if (ecnt & ev_any[i]) begin
        cnt_next[i] = dec;
      end else if (free_run & zero) begin
        cnt_next[i] = ilr;
      end else if (free_run) begin
        cnt_next[i] = dec;
      end
    end

    assign pre_next[i] = ~prd ? pre_reg[i]
                       : pre_zero ? prescale_value[i] : pre_reg[i] - PRE_ONE;
    assign en_next[i] = (en_reg[i] & ~en_clr[i] & ~hw_clr) | en_set[i];
    assign set_f[i].cap_event = ce_hit[i];
    assign set_f[i].cap_match = cm_hit[i];
    assign set_f[i].timeout = to_hit[i] | (i == 0 && to32);
    assign raw_next[i] = (raw_reg[i] & ~status_clear_reg[i]) | set_f[i];
    wire [15:0] half32 = c32_reg[HALF*i +: HALF];
    wire hold_cap = split & capm & m.capture_mode_bit;
    assign val_next[i] = ~split ? half32
                       : ce_hit[i] ? cnt
                       : hold_cap ? val_reg[i] : cnt;
    assign lvl_next[i] = ~pwr_v[i] ? lvl_reg[i]
                       : cnt == ilr ? 1'b1
                       : cnt == mat ? 1'b0 : lvl_reg[i];

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        sy1_reg[i] <= 1'b0;
        sy2_reg[i] <= 1'b0;
        old_reg[i] <= 1'b0;
        en_reg[i] <= 1'b0;
        cnt_reg[i] <= LOAD_RST;
        pre_reg[i] <= PRE_ZERO;
        val_reg[i] <= LOAD_RST;
        lvl_reg[i] <= 1'b0;
        pwm_reg[i] <= 1'b0;
        raw_reg[i] <= FLAGS_NONE;
        msk_reg[i] <= FLAGS_NONE;
      end else if (clk_en) begin
        sy1_reg[i] <= capture_compare_pin[i];
        sy2_reg[i] <= sy1_reg[i];
        old_reg[i] <= sy2_reg[i];
        en_reg[i] <= en_next[i];
        cnt_reg[i] <= cnt_next[i];
        pre_reg[i] <= pre_next[i];
        val_reg[i] <= val_next[i];
        lvl_reg[i] <= lvl_next[i];
        pwm_reg[i] <= lvl_next[i] ^ c.pwm_output_level_bit;
        raw_reg[i] <= raw_next[i];
        msk_reg[i] <= raw_next[i] & interrupt_mask_reg[i];
      end
    end
  end

  assign timer_en = en_reg;
  assign pwm_out = pwm_reg;
  assign timer_value_readback = val_reg;
  assign raw_status_reg = raw_reg;
  assign masked_status_reg = msk_reg;
  assign rtc_match_raw_flag = rtc_reg;
  assign rtc_match_masked_flag = rmsk_reg;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  match_flag_a: assert property (clk_en && cm_hit[0] |=> raw_reg[0].cap_match)
    else $error("count match did not raise flag");
  match_stop_a: assert property (clk_en && cm_hit[0] && !en_set[0]
    |=> !en_reg[0] && cnt_reg[0] == $past(interval_load_value[0]))
    else $error("count match did not stop and reload");
  edge_ignore_a: assert property (clk_en && !en_reg[0]
    |=> cnt_reg[0] == $past(interval_load_value[0]))
    else $error("disabled timer did not hold its load value");
  edge_dec_a: assert property (clk_en && ev_any[0] && split && en_reg[0] && !cm_hit[0]
    && per_timer_mode_reg[0] == 4'h3 && !(debug_halt && timer_control_reg[0].stall)
    |=> cnt_reg[0] == $past(cnt_reg[0]) - CNT_ONE)
    else $error("edge count did not decrement by one");
  capture_a: assert property (clk_en && ce_hit[0]
    |=> val_reg[0] == $past(cnt_reg[0]) && raw_reg[0].cap_event)
    else $error("edge time capture wrong");
  pwm_quiet_a: assert property (clk_en && pwr_v[1]
    |=> (raw_reg[1] & ~$past(raw_reg[1])) == FLAGS_NONE)
    else $error("pwm mode raised a flag");
  pwm_high_a: assert property (clk_en && pwr_v[1]
    && cnt_reg[1] == interval_load_value[1]
    |=> pwm_out[1] == !$past(timer_control_reg[1].pwm_output_level_bit))
    else $error("pwm output not asserted at load value");
  pwm_low_a: assert property (clk_en && pwr_v[1]
    && cnt_reg[1] == match_value[1] && cnt_reg[1] != interval_load_value[1]
    |=> pwm_out[1] == $past(timer_control_reg[1].pwm_output_level_bit))
    else $error("pwm output not released at match value");
  flag_clear_a: assert property (clk_en && status_clear_reg[1].timeout
    && !set_f[1].timeout |=> !raw_reg[1].timeout && !masked_status_reg[1].timeout)
    else $error("clear did not drop timeout flags");
  oneshot_stop_a: assert property (clk_en && to_hit[1] && !en_set[1]
    && per_timer_mode_reg[1].timer_mode_field == TM_ONESHOT |=> !en_reg[1])
    else $error("one-shot timer kept running");
  wide_reload_a: assert property (clk_en && to32
    |=> c32_reg == $past(load32) && raw_reg[0].timeout)
    else $error("wide timeout did not reload and flag");
  rtc_match_a: assert property (clk_en && rtc_hit
    |=> rtc_match_raw_flag && c32_reg == C32_ZERO && en_reg[0])
    else $error("rtc match mishandled");
  cnt_match_c: cover property (cm_hit[0]);
  cnt_edge_c: cover property (ce_hit[0]);
  pwm_run_c: cover property (pwr_v[1] && pwm_out[1] ##1 !pwm_out[1]);
  wide_to_c: cover property (to32);
  rtc_hit_c: cover property (rtc_hit);
endmodule

// ===== gtm_edge_src.sv
/*
  far-side edge source for one capture/compare pin.
  assumes the caller steps it from the bench clock's falling edge.
*/
`timescale 1ns/100ps
module gtm_edge_src (
  // clock
  input wire logic ref_clk,
  // pin
  output logic     pin
);
  initial pin = 1'b0;

  // new level just after a falling edge, then held at least two clocks
  task automatic put(input logic lvl, input int hold_cyc);
    @(negedge ref_clk);
    pin = lvl;
    repeat ((hold_cyc < 2) ? 2 : hold_cyc) @(negedge ref_clk);
  endtask
endmodule

// ===== gtm_core_bench.sv
/*
  self-checking bench for gtm_core: edge count, edge time, periodic, one-shot, pwm,
  wide periodic/one-shot with debug halt and clock enable freeze.
  assumes gtm_pkg and gtm_edge_src are compiled before it.
*/
`timescale 1ns/100ps
module gtm_core_bench;
  import gtm_pkg::*;
  logic                ref_clk = 1'b0;
  logic                arst_n  = 1'b0;
  logic                halt    = 1'b0;
  logic                ce      = 1'b1;
  logic [2:0]          cfg     = CFG_SPLIT;
  gtm_mode_t [1:0]     mode    = '0;
  gtm_ctl_t [1:0]      ctl     = '0;
  logic [1:0]          en_set  = '0;
  logic [1:0]          en_clr  = '0;
  logic [1:0][15:0]    ilr     = {2{LOAD_RST}};
  logic [1:0][15:0]    mt      = {2{LOAD_RST}};
  logic [1:0][7:0]     pre     = '0;
  gtm_flags_t [1:0]    msk_in  = '0;
  gtm_flags_t [1:0]    sclr    = '0;
  logic [1:0]          pin;
  logic [1:0]          pwm;
  logic [1:0]          ten;
  logic [1:0][15:0]    rb;
  gtm_flags_t [1:0]    raw;
  gtm_flags_t [1:0]    msk;
  int                  fails = 0;
  int                  total_checks = 0;

  always #50 ref_clk = ~ref_clk;

  gtm_edge_src src0 (.ref_clk(ref_clk), .pin(pin[0]));
  gtm_edge_src src1 (.ref_clk(ref_clk), .pin(pin[1]));

  gtm_core dut_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(ce),
    .global_config_field(cfg), .per_timer_mode_reg(mode), .timer_control_reg(ctl),
    .rtc_stall_override_bit(1'b0), .debug_halt(halt),
    .en_set(en_set), .en_clr(en_clr),
    .interval_load_value(ilr), .match_value(mt), .prescale_value(pre),
    .interrupt_mask_reg(msk_in), .status_clear_reg(sclr),
    .rtc_match_mask(1'b0), .rtc_match_clear(1'b0),
    .capture_compare_pin(pin), .pwm_out(pwm), .timer_en(ten),
    .timer_value_readback(rb), .raw_status_reg(raw), .masked_status_reg(msk),
    .rtc_match_raw_flag(), .rtc_match_masked_flag()
  );

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic end_sim();
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic pulse_en(input int t, input bit on);
    if (on)
      en_set[t] = 1'b1;
    else
      en_clr[t] = 1'b1;
    tick(1);
    if (on)
      en_set[t] = 1'b0;
    else
      en_clr[t] = 1'b0;
  endtask

  task automatic clr(input int t);
    sclr[t] = 3'h7;
    tick(1);
    sclr = '0;
  endtask

  task automatic t_count();
    mode[0] = '{1'b0, 1'b0, TM_CAPTURE};
    ctl[0].event_sel = EV_BOTH;
    ilr[0] = 16'h000A;
    mt[0] = 16'h0006;
    msk_in[0] = 3'h2;
    pulse_en(0, 1);
    for (int i = 1; i <= 6; i++) begin
      src0.put(i[0], 4);
      tick(2);
      if (i == 3) chk(rb[0] === 16'h0007 && ten[0] === 1'b1, "edge count step");
      if (i == 4) chk(raw[0].cap_match === 1'b1 && msk[0].cap_match === 1'b1, "match flag");
      if (i == 4) chk(ten[0] === 1'b0, "enable not cleared at match");
    end
    chk(rb[0] === 16'h000A, "no reload or late edges counted");
    clr(0);
    chk(raw[0] === FLAGS_NONE && msk[0] === FLAGS_NONE, "flags not cleared");
  endtask

  task automatic t_time();
    logic [15:0] v1;
    mode[0] = '{1'b0, 1'b1, TM_CAPTURE};
    ctl[0].event_sel = EV_RISE;
    ilr[0] = LOAD_RST;
    msk_in[0] = 3'h4;
    pulse_en(0, 1);
    tick(20);
    src0.put(1'b1, 4);
    tick(2);
    v1 = rb[0];
    chk(raw[0].cap_event === 1'b1 && msk[0].cap_event === 1'b1, "capture flag");
    src0.put(1'b0, 10);
    chk(rb[0] === v1 && ten[0] === 1'b1, "capture moved on fall");
    src0.put(1'b1, 4);
    tick(2);
    chk(16'(v1 - rb[0]) === 16'd18, "capture spacing");
    pulse_en(0, 0);
  endtask

  task automatic t_period();
    int n;
    mode[1] = '{1'b0, 1'b0, TM_PERIODIC};
    ilr[1] = 16'h0003;
    pre[1] = 8'h01;
    msk_in[1] = 3'h1;
    pulse_en(1, 1);
    for (n = 0; n < 40 && raw[1].timeout !== 1'b1; n++) tick(1);
    clr(1);
    for (n = 1; n < 40 && raw[1].timeout !== 1'b1; n++) tick(1);
    chk(n == 8 && ten[1] === 1'b1 && msk[1].timeout === 1'b1, "periodic timeout");
    pulse_en(1, 0);
    clr(1);
    mode[1].timer_mode_field = TM_ONESHOT;
    pulse_en(1, 1);
    for (n = 0; n < 40 && raw[1].timeout !== 1'b1; n++) tick(1);
    tick(1);
    chk(raw[1].timeout === 1'b1 && ten[1] === 1'b0, "one-shot still running");
  endtask

  task automatic t_pwm(input logic lvl, input int hi);
    int n;
    pulse_en(1, 0);
    clr(1);
    mode[1] = '{1'b1, 1'b0, TM_PERIODIC};
    ctl[1].pwm_output_level_bit = lvl;
    ilr[1] = 16'h0009;
    mt[1] = 16'h0002;
    pulse_en(1, 1);
    tick(25);
    n = 0;
    repeat (20) begin
      tick(1);
      n += int'(pwm[1] === 1'b1);
    end
    chk(n == hi, "pwm duty");
    chk(raw[1] === FLAGS_NONE && msk[1] === FLAGS_NONE, "pwm set a flag");
  endtask

  task automatic t_wide();
    int n;
    logic [31:0] v;
    pulse_en(1, 0);
    cfg = CFG_WIDE;
    mode[0] = '{1'b0, 1'b0, TM_PERIODIC};
    ctl[0].stall = 1'b1;
    ilr = {16'h0000, 16'h0005};
    msk_in[0] = 3'h1;
    pulse_en(0, 1);
    for (n = 0; n < 40 && raw[0].timeout !== 1'b1; n++) tick(1);
    clr(0);
    for (n = 1; n < 40 && raw[0].timeout !== 1'b1; n++) tick(1);
    chk(n == 6 && ten[0] === 1'b1 && msk[0].timeout === 1'b1, "wide periodic");
    halt = 1'b1;
    tick(1);
    v = {rb[1], rb[0]};
    tick(3);
    chk({rb[1], rb[0]} === v, "wide counter ran during debug halt");
    halt = 1'b0;
    ce = 1'b0;
    tick(3);
    ce = 1'b1;
    chk({rb[1], rb[0]} === v, "counter ran with clock enable low");
    pulse_en(0, 0);
    clr(0);
    mode[0].timer_mode_field = TM_ONESHOT;
    pulse_en(0, 1);
    for (n = 0; n < 40 && raw[0].timeout !== 1'b1; n++) tick(1);
    tick(1);
    chk(raw[0].timeout === 1'b1 && ten[0] === 1'b0 && {rb[1], rb[0]} === 32'h0000_0005,
        "wide one-shot still running");
    ilr = {16'h00A5, 16'h005A};
    tick(2);
    chk({rb[1], rb[0]} === 32'h00A5_005A, "wide load halves misplaced");
    cfg = CFG_RTC;
    tick(2);
    chk({rb[1], rb[0]} === RTC_START, "rtc counter not preset");
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    end_sim();
  end

  initial begin
    tick(6);
    arst_n = 1'b1;
    tick(1);
    chk(rb === {2{LOAD_RST}} && ten === 2'h0 && raw === '0 && pwm === 2'h0, "reset");
    t_count();
    t_time();
    t_period();
    t_pwm(1'b0, 14);
    t_pwm(1'b1, 6);
    t_wide();
    end_sim();
  end
endmodule
